/* File: rtl/asr_consts.vh */
// Purpose: Constants of the static memory controller
// Assumes: 100 MHz ref_clk, 10 ns period
// Notes:   Times in ns, cycle counts derived below
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH

`define ASR_CLK_PERIOD_NS   10
`define ASR_ADDR_W          19
`define ASR_DATA_W          16
// Read cycle and access times
`define ASR_T_READ_CYCLE_NS 55
`define ASR_T_ACCESS_NS     55
// Write cycle times
`define ASR_T_WRITE_CYCLE_NS 45
`define ASR_T_WRITE_PULSE_NS 35
`define ASR_T_WRITE_SETUP_NS 25
`define ASR_T_STROBE_FLOAT_NS 18
`define ASR_T_DRIVE_RELEASE_NS 18
// Least times round up
`define ASR_CYC_UP(t) (((t) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_RD_CYC     `ASR_CYC_UP(`ASR_T_READ_CYCLE_NS)
`define ASR_WR_PULSE_CYC `ASR_CYC_UP(`ASR_T_WRITE_PULSE_NS)
`define ASR_WR_SETUP_CYC `ASR_CYC_UP(`ASR_T_WRITE_SETUP_NS)
`define ASR_FLOAT_CYC  `ASR_CYC_UP(`ASR_T_STROBE_FLOAT_NS)
`define ASR_TURN_CYC   `ASR_CYC_UP(`ASR_T_DRIVE_RELEASE_NS)
`define ASR_CNT_W      4
// Pin filter latency: three stages plus the agreed-value flop
`define ASR_SYNC_CYC   4

`endif

/* File: rtl/asr_pin_sync.v */
// Purpose: Three-stage input synchroniser for data pins
// Assumes: Data pins change asynchronously to ref_clk
// Notes:   A bit changes once second and third stages agree
`timescale 1ns/1ps
module asr_pin_sync #(
   parameter W = 16
)(
   // Clock and reset
   input  wire         ref_clk,
   input  wire         rst_n,
   // Pin side
   input  wire [W-1:0] pin_in,
   // Synchronised side
   output wire [W-1:0] sync_out
);

   genvar i;
   // One filter per bit
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg s1;
         reg s2;
         reg s3;
         reg held;
         always @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1   <= 1'b0;
               s2   <= 1'b0;
               s3   <= 1'b0;
               held <= 1'b0;
            end
            else
            begin
               s1 <= pin_in[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3)
                  held <= s3; // Accept only agreed value
            end
         end
         assign sync_out[i] = held;
      end
   endgenerate

endmodule

/* File: rtl/asr_host_ctrl.v */
// Purpose: Host controller for an asynchronous 512K x 16 static memory
// Assumes: One request at a time; memory pins are unclocked levels
// Notes:   Writes are strobe controlled with drive control held off
// Overview of operation
// RULE_01 - Write only while strobe, both selects and a lane enable active.
// RULE_02 - Data held stable past the strobe edge that ends the write.
// RULE_03 - Strobe write with drive on lasts float delay plus data setup.
// RULE_04 - Memory floats its data pins in writes with drive control off.
// RULE_05 - Memory stays floating when selects drop with the strobe.
// RULE_06 - Host never drives the bus while the memory may drive it.
// RULE_07 - Write strobe stays inactive through every read cycle.
// RULE_08 - Address valid no later than selects and lane enables assert.
// RULE_09 - Memory gives new data on each address change while selected.
// RULE_10 - Reads drive only enabled lanes, low on 0-7, high on 8-15.
// RULE_11 - Writes store only enabled lanes, other byte unchanged.
// RULE_12 - Memory deselected when a select is off or both lanes off.
// RULE_13 - Memory floats all pins when drive control is off in a read.
`include "asr_consts.vh"
`timescale 1ns/1ps
module asr_host_ctrl (
   // Clock and reset
   input  wire                   ref_clk,
   input  wire                   rstn,
   // User request
   input  wire                   req_valid,
   input  wire                   req_write,
   input  wire [`ASR_ADDR_W-1:0] req_addr,
   input  wire [`ASR_DATA_W-1:0] req_wdata,
   input  wire [1:0]             req_lanes,
   output wire                   req_ready,
   // User answer
   output reg                    rsp_valid,
   output reg  [`ASR_DATA_W-1:0] rsp_rdata,
   // Memory pins
   output reg  [`ASR_ADDR_W-1:0] mem_addr,
   output reg                    select_low_active_n,
   output reg                    select_high_active,
   output reg                    write_strobe_n,
   output reg                    output_drive_n,
   output reg                    upper_lane_enable_n,
   output reg                    lower_lane_enable_n,
   input  wire [`ASR_DATA_W-1:0] mem_data_in,
   output reg  [`ASR_DATA_W-1:0] mem_data_out,
   output reg                    mem_data_oe
);

   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_SETUP = 3'd1;
   localparam [2:0] ST_READ  = 3'd2;
   localparam [2:0] ST_WRITE = 3'd3;
   localparam [2:0] ST_HOLD  = 3'd4;
   localparam [2:0] ST_TURN  = 3'd5;

   // Read samples after the access time and the four pin filter flops
   localparam integer RD_LAST_I   = `ASR_RD_CYC + `ASR_SYNC_CYC - 1;
   // Strobe low for the longer of pulse width and float plus setup
   localparam integer WR_SPAN_I   = `ASR_FLOAT_CYC + `ASR_WR_SETUP_CYC;
   localparam integer WR_LAST_I   = (`ASR_WR_PULSE_CYC > WR_SPAN_I) ?
                                    `ASR_WR_PULSE_CYC - 1 : WR_SPAN_I - 1;
   localparam integer TURN_LAST_I = `ASR_TURN_CYC - 1;
   // Cut to the counter width on purpose
   localparam [`ASR_CNT_W-1:0] RD_LAST   = RD_LAST_I[`ASR_CNT_W-1:0];
   localparam [`ASR_CNT_W-1:0] WR_LAST   = WR_LAST_I[`ASR_CNT_W-1:0];
   localparam [`ASR_CNT_W-1:0] TURN_LAST = TURN_LAST_I[`ASR_CNT_W-1:0];

   reg                    rst_s1;
   reg                    rst_n;
   reg [2:0]              state;
   reg [`ASR_CNT_W-1:0]   cnt;
   reg                    is_write;
   wire [`ASR_DATA_W-1:0] data_sync;
   reg [1:0]              req_lanes_q;

   // Reset release through two flops
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Read data pins cross into ref_clk
   asr_pin_sync #(
      .W (`ASR_DATA_W)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pin_in   (mem_data_in),
      .sync_out (data_sync)
   );

   // Ready only while idle; the request is taken on that edge
   assign req_ready = (state == ST_IDLE);

   // Access sequencer
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state               <= ST_IDLE;
         cnt                 <= 4'h0;
         is_write            <= 1'b0;
         rsp_valid           <= 1'b0;
         rsp_rdata           <= 16'h0000;
         mem_addr            <= 19'h00000;
         select_low_active_n <= 1'b1;
         select_high_active  <= 1'b0;
         write_strobe_n      <= 1'b1;
         output_drive_n      <= 1'b1;
         upper_lane_enable_n <= 1'b1;
         lower_lane_enable_n <= 1'b1;
         mem_data_out        <= 16'h0000;
         mem_data_oe         <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (req_valid && req_lanes != 2'b00)
               begin
                  // Address and data first, selects next cycle
                  mem_addr     <= req_addr; // RULE_08
                  is_write     <= req_write;
                  mem_data_out <= req_wdata;
                  upper_lane_enable_n <= 1'b1;
                  lower_lane_enable_n <= 1'b1;
                  state <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               select_low_active_n <= 1'b0;
               select_high_active  <= 1'b1;
               upper_lane_enable_n <= ~req_lanes_q[1];
               lower_lane_enable_n <= ~req_lanes_q[0];
               cnt <= 4'h0;
               if (is_write)
               begin
                  // Drive off keeps memory floating
                  output_drive_n <= 1'b1; // RULE_04
                  write_strobe_n <= 1'b0; // RULE_01
                  mem_data_oe    <= 1'b1; // RULE_06
                  state <= ST_WRITE;
               end
               else
               begin
                  // Memory may drive once selected with drive on
                  write_strobe_n <= 1'b1; // RULE_07
                  output_drive_n <= 1'b0;
                  state <= ST_READ;
               end
            end
            ST_READ:
            begin
               cnt <= cnt + 4'h1;
               if (cnt == RD_LAST)
               begin
                  // Pin data has passed the filter by now
                  rsp_rdata           <= data_sync; // RULE_10
                  rsp_valid           <= 1'b1;
                  output_drive_n      <= 1'b1;
                  select_low_active_n <= 1'b1;
                  select_high_active  <= 1'b0;
                  upper_lane_enable_n <= 1'b1;
                  lower_lane_enable_n <= 1'b1;
                  cnt   <= 4'h0;
                  state <= ST_TURN;
               end
            end
            ST_WRITE:
            begin
               cnt <= cnt + 4'h1;
               if (cnt == WR_LAST)
               begin
                  // Strobe edge ends the overlap
                  write_strobe_n <= 1'b1; // RULE_03
                  state <= ST_HOLD;
               end
            end
            ST_HOLD:
            begin
               // Data held one cycle past the ending edge
               mem_data_oe         <= 1'b0; // RULE_02
               select_low_active_n <= 1'b1;
               select_high_active  <= 1'b0;
               upper_lane_enable_n <= 1'b1;
               lower_lane_enable_n <= 1'b1;
               rsp_valid           <= 1'b1;
               state <= ST_IDLE;
            end
            ST_TURN:
            begin
               // Wait for memory release before any drive
               cnt <= cnt + 4'h1;
               if (cnt == TURN_LAST)
                  state <= ST_IDLE; // RULE_06
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Lanes captured with the request
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         req_lanes_q <= 2'b00;
      else if (state == ST_IDLE && req_valid)
         req_lanes_q <= req_lanes; // RULE_11
   end

endmodule

/* File: dv/asr_host_ctrl_chk.sv */
// Purpose: Port checks of the static memory host controller
// Assumes: One clock, rstn active low
// Notes:   Cycle counts follow the controller's fixed walk
`include "asr_consts.vh"
`timescale 1ns/1ps
module asr_host_ctrl_chk (
   // Clock and reset
   input wire                   ref_clk,
   input wire                   rstn,
   // User side
   input wire                   req_valid,
   input wire                   req_write,
   input wire [1:0]             req_lanes,
   input wire                   req_ready,
   input wire                   rsp_valid,
   // Memory pins
   input wire [`ASR_ADDR_W-1:0] mem_addr,
   input wire                   select_low_active_n,
   input wire                   select_high_active,
   input wire                   write_strobe_n,
   input wire                   output_drive_n,
   input wire                   upper_lane_enable_n,
   input wire                   lower_lane_enable_n,
   input wire [`ASR_DATA_W-1:0] mem_data_out,
   input wire                   mem_data_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Accepted request
   wire take = req_valid && req_ready && (req_lanes != 2'b00);
   wire lanes_n = upper_lane_enable_n && lower_lane_enable_n;

   chk_write_overlap: assert property (!write_strobe_n |->
      !select_low_active_n && select_high_active && !lanes_n)
      else $error("strobe low outside selection");
   chk_strobe_width: assert property ($fell(write_strobe_n) |->
      !write_strobe_n [*5]) else $error("write strobe too short");
   chk_data_hold: assert property ($rose(write_strobe_n) |->
      mem_data_oe && $stable(mem_data_out)) else $error("data not held");
   chk_read_float: assert property (!output_drive_n |->
      !mem_data_oe) else $error("host drives during read");
   chk_read_strobe: assert property (!output_drive_n |->
      write_strobe_n) else $error("strobe low during read");
   chk_bus_turn: assert property ($rose(output_drive_n) |->
      !mem_data_oe [*3]) else $error("no turnaround after read");
   chk_addr_first: assert property ($fell(select_low_active_n) |->
      $stable(mem_addr)) else $error("address moved with select");
   chk_lane_map: assert property (take |-> ##2
      {upper_lane_enable_n, lower_lane_enable_n} == ~$past(req_lanes, 2))
      else $error("lane enables wrong");
   chk_write_done: assert property (take && req_write |->
      ##1 !rsp_valid [*7] ##1 rsp_valid) else $error("write answer late");
   chk_read_done: assert property (take && !req_write |->
      ##1 !rsp_valid [*8] ##1 !rsp_valid [*3] ##1 rsp_valid)
      else $error("read answer late");
   cov_write: cover property (take && req_write);
   cov_read: cover property (take && !req_write);
   cov_upper: cover property (take && req_lanes == 2'b10);
endmodule
bind asr_host_ctrl asr_host_ctrl_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
   .req_valid(req_valid), .req_write(req_write), .req_lanes(req_lanes),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
   .select_low_active_n(select_low_active_n),
   .select_high_active(select_high_active),
   .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
   .upper_lane_enable_n(upper_lane_enable_n),
   .lower_lane_enable_n(lower_lane_enable_n),
   .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

/* File: dv/asr_sram_model.sv */
// Purpose: Behavioural 512K x 16 static memory on the controller pins
// Assumes: Pins are levels; clk shapes floating lanes and clocks the contention watch
// Notes:   Floating lanes show a pattern that flips every cycle
`timescale 1ns/1ps
module asr_sram_model #(
   parameter ACC_NS = 55
)(
   // Pattern clock
   input  wire        clk,
   // Memory pins
   input  wire [18:0] addr,
   input  wire        cs_n,
   input  wire        cs,
   input  wire        we_n,
   input  wire        oe_n,
   input  wire        ub_n,
   input  wire        lb_n,
   input  wire [15:0] host_d,
   input  wire        host_oe,
   // Resolved bus and contention flag
   output wire [15:0] bus,
   output reg         clash
);
   logic [15:0] mem [0:524287];
   logic [15:0] fl = 16'h5a5a;
   logic [15:0] rdw = 16'h0000;
   integer      chg = 0;
   wire [31:0]  chg_late;
   wire         settled;
   // Selection and lane drive
   wire sel = !cs_n && cs && !(ub_n && lb_n);
   wire rd  = sel && we_n && !oe_n;
   wire dlo = rd && !lb_n;
   wire dhi = rd && !ub_n;
   initial clash = 1'b0;
   // Level store of enabled lanes while overlap lasts
   always @(sel, we_n, lb_n, ub_n, addr, bus)
      if (sel && !we_n)
      begin
         if (!lb_n) mem[addr][7:0] = bus[7:0];
         if (!ub_n) mem[addr][15:8] = bus[15:8];
      end
   // Data valid once address and controls rest for the access time
   always @(addr, we_n, sel)
      chg = chg + 1;
   assign #ACC_NS chg_late = chg;
   assign settled = (chg_late == chg);
   // Unknown until settled, then the stored word
   always @(settled)
      if (settled === 1'b1)
         rdw = mem[addr];
      else
         rdw = 16'hxxxx;
   // Float pattern and contention watch
   always @(posedge clk)
   begin
      fl <= ~fl;
      if (host_oe && (dlo || dhi)) clash <= 1'b1;
   end
   assign bus[7:0]  = host_oe ? host_d[7:0] : (dlo ? rdw[7:0] : fl[7:0]);
   assign bus[15:8] = host_oe ? host_d[15:8] : (dhi ? rdw[15:8] : fl[15:8]);
endmodule

/* File: dv/async_sram_byte_lane_access_test.sv */
// Purpose: Self-checking bench of the static memory host controller
// Assumes: 100 MHz ref_clk; inputs change 1 ns after rising edge
// Notes:   Memory model on the pins, checker bound to the controller
`timescale 1ns/1ps
module async_sram_byte_lane_access_test;
   logic        ref_clk = 1'b0, rstn = 1'b0;
   logic        req_valid = 1'b0, req_write = 1'b0;
   logic [18:0] req_addr = 19'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0]  req_lanes = 2'b00;
   wire         req_ready, rsp_valid, cs_n, cs, we_n, oe_n, ub_n, lb_n;
   wire         oe, clash;
   wire [15:0]  rsp_rdata, din, dout;
   wire [18:0]  maddr;
   integer      failures = 0, checks_done = 0;

   // Clock
   always #5 ref_clk = ~ref_clk;
   asr_host_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_lanes(req_lanes), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(maddr),
      .select_low_active_n(cs_n), .select_high_active(cs),
      .write_strobe_n(we_n), .output_drive_n(oe_n),
      .upper_lane_enable_n(ub_n), .lower_lane_enable_n(lb_n),
      .mem_data_in(din), .mem_data_out(dout), .mem_data_oe(oe));
   asr_sram_model u_mem (.clk(ref_clk), .addr(maddr), .cs_n(cs_n), .cs(cs),
      .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .host_d(dout),
      .host_oe(oe), .bus(din), .clash(clash));

   task automatic finish_test;
      if (failures == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One request, held until taken, then wait for its answer
   task automatic xfer(input logic w, input logic [18:0] a,
                       input logic [15:0] d, input logic [1:0] l);
      integer n;
      begin
         n = 0;
         req_valid = 1'b1;
         req_write = w;
         req_addr = a;
         req_wdata = d;
         req_lanes = l;
         while (req_ready !== 1'b1 && n < 80)
         begin
            @(posedge ref_clk);
            #1 n = n + 1;
         end
         @(posedge ref_clk);
         #1 req_valid = 1'b0;
         while (rsp_valid !== 1'b1 && n < 80)
         begin
            @(posedge ref_clk);
            #1 n = n + 1;
         end
         if (n >= 80)
         begin
            failures = failures + 1;
            finish_test;
         end
      end
   endtask
   // Full word at the top address, read straight after
   task automatic t_word;
      xfer(1'b1, 19'h7ffff, 16'ha5c3, 2'b11);
      xfer(1'b0, 19'h7ffff, 16'h0000, 2'b11);
      check(rsp_rdata, 16'ha5c3);
   endtask
   // Single-lane writes keep the other byte
   task automatic t_lanes;
      xfer(1'b1, 19'h00002, 16'hffff, 2'b11);
      xfer(1'b1, 19'h00002, 16'h0012, 2'b01);
      xfer(1'b0, 19'h00002, 16'h0000, 2'b11);
      check(rsp_rdata, 16'hff12);
      xfer(1'b1, 19'h00002, 16'h3400, 2'b10);
      xfer(1'b0, 19'h00002, 16'h0000, 2'b10);
      check({8'h00, rsp_rdata[15:8]}, 16'h0034);
      xfer(1'b0, 19'h00002, 16'h0000, 2'b01);
      check({8'h00, rsp_rdata[7:0]}, 16'h0012);
   endtask
   // No lane enabled: request ignored, controller stays ready
   task automatic t_ignore;
      integer i, bad;
      begin
         bad = 0;
         // Let a read turnaround finish first
         repeat (3) @(posedge ref_clk);
         #1 req_valid = 1'b1;
         req_lanes = 2'b00;
         for (i = 0; i < 12; i = i + 1)
         begin
            @(posedge ref_clk);
            #1 if (rsp_valid !== 1'b0 || req_ready !== 1'b1) bad = bad + 1;
         end
         req_valid = 1'b0;
         check(bad[15:0], 16'h0000);
      end
   endtask

   // Mid-run reset: pins idle at once, then a fresh read still works
   task automatic t_reset;
      logic [7:0] pins;
      begin
         rstn = 1'b0;
         repeat (2) @(posedge ref_clk);
         #1 pins = {rsp_valid, cs_n, cs, we_n, oe_n, ub_n, lb_n, oe};
         check({8'h00, pins}, 16'h005e);
         rstn = 1'b1;
         repeat (3) @(posedge ref_clk);
         #1 xfer(1'b0, 19'h7ffff, 16'h0000, 2'b11);
         check(rsp_rdata, 16'ha5c3);
      end
   endtask

   initial
   begin
      repeat (10) @(posedge ref_clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 t_word;
      t_lanes;
      t_ignore;
      t_reset;
      check({15'h0000, clash}, 16'h0000);
      finish_test;
   end
endmodule
